// ### pkg/cisb_defines.vh
// constants for the control input switch bank
`ifndef CISB_DEFINES_VH
`define CISB_DEFINES_VH
// number of switches
`define CISB_NUM_SW 32
// per-switch command codes (2 bits)
`define CISB_CMD_NOP 2'h0
`define CISB_CMD_SET 2'h1
`define CISB_CMD_RESET 2'h2
`define CISB_CMD_PULSE 2'h3
// label selector codes (2 bits)
`define CISB_LBL_SET_RESET 2'h0
`define CISB_LBL_IN_OUT 2'h1
`define CISB_LBL_EN_DIS 2'h2
`define CISB_LBL_ON_OFF 2'h3
// reset values
`define CISB_STATE_RST 32'h00000000
`define CISB_HOTKEY_RST 32'hFFFFFFFF
`define CISB_MODE_RST 32'h00000000
// pulse timing
`define CISB_PULSE_MS 10
`define CISB_CLK_HZ 20000000
`define CISB_PULSE_CYC ((`CISB_CLK_HZ / 1000) * `CISB_PULSE_MS)
`endif

// ### src/cisb_switch_bank.v
// control input switch bank: 32 software switches with retention
`timescale 1ns/100ps
`include "cisb_defines.vh"
//
// Function
// - a 32-bit status word returns the present state of every switch.
// - writing the status word sets switches with a one, resets with zero.
// - each switch has a command cell with no operation, set or reset.
// - local and remote paths set and reset switches with equal effect.
// - each switch has a latched/pulsed bit, latched after reset.
// - a latched switch stays set until a reset command from any path or a status word write with zero.
// - a pulsed switch asserts on set, holds 10 ms, then clears itself.
// - a hotkey enable word assigns each switch to the hotkey path.
// - assigned switches take set, reset or pulse through the hotkey path.
// - a four-way label selector per switch changes wording only.
// - switch states drive the scheme logic as 32 separate signals.
// - latched states are kept in battery storage, pulsed ones are not.
// - on supply return every retained switch regains its last state.
// - with battery absent or flat, every switch clears to zero on return.
//
// timing notes for users of this block:
// - commands and word writes are ignored for three cycles after reset,
//   while the battery syncs settle and the restore value loads
// - every readback port lags the internal state by one cycle
// - set beats reset when both reach one switch in one cycle
// - a local word write beats a remote one in the same cycle
// - pulse code on the hotkey path acts as set; on a latched switch it
//   simply latches
// - PULSE_CYC must fit the pulse counter width below
// - label selectors are readback only and never touch switch state
//
module cisb_switch_bank #(
   parameter NUM_SW = `CISB_NUM_SW,
   parameter PULSE_CYC = `CISB_PULSE_CYC
) (
   input wire clk, // 20 MHz system clock
   input wire rst_n, // sync reset, supply restoration
   input wire loc_word_we, // local menu status word write
   input wire [NUM_SW-1:0] loc_word_wdata, // local status word data
   input wire rem_word_we, // remote serial status word write
   input wire [NUM_SW-1:0] rem_word_wdata, // remote status word data
   input wire loc_cmd_valid, // local command cell strobe
   input wire [4:0] loc_cmd_idx, // local command switch index
   input wire [1:0] loc_cmd_code, // local command code
   input wire rem_cmd_valid, // remote command cell strobe
   input wire [4:0] rem_cmd_idx, // remote command switch index
   input wire [1:0] rem_cmd_code, // remote command code
   input wire hk_cmd_valid, // hotkey command strobe
   input wire [4:0] hk_cmd_idx, // hotkey switch index
   input wire [1:0] hk_cmd_code, // hotkey command code
   input wire mode_we, // latched/pulsed word write
   input wire [NUM_SW-1:0] mode_wdata, // one = pulsed
   input wire hotkey_we, // hotkey assign word write
   input wire [NUM_SW-1:0] hotkey_wdata, // hotkey assign data
   input wire label_we, // label selector write
   input wire [4:0] label_idx, // label selector switch index
   input wire [1:0] label_wdata, // label selector code
   input wire [4:0] label_rd_idx, // label readback index
   input wire batt_ok_pin, // battery present and charged
   input wire [NUM_SW-1:0] retain_word, // battery-backed stored states
   output reg [NUM_SW-1:0] switch_state_word, // status word readback
   output reg [NUM_SW-1:0] switch_logic_signals, // to scheme logic
   output reg [NUM_SW-1:0] hotkey_assign_word, // hotkey assign readback
   output reg [NUM_SW-1:0] mode_word, // latched/pulsed readback
   output reg [1:0] label_rd_data, // label selector readback
   output reg retain_we, // write strobe to battery storage
   output reg [NUM_SW-1:0] retain_wdata // latched states to store
);

   // pulse counter width; holds about one million cycles, so a longer
   // pulse or a faster clock needs a wider counter
   localparam CW = 20;

   // one bit per switch decoded from an index
   function [NUM_SW-1:0] onehot;
      input [4:0] idx;
      begin
         onehot = {{(NUM_SW-1){1'b0}}, 1'b1} << idx;
      end
   endfunction

   reg [NUM_SW-1:0] sw_q;
   reg [NUM_SW-1:0] sw_d;
   reg [NUM_SW-1:0] mode_q;
   reg [NUM_SW-1:0] hk_q;
   reg [1:0] label_q [0:NUM_SW-1];
   reg [CW-1:0] cnt_q [0:NUM_SW-1];
   reg [NUM_SW-1:0] restart_d;
   reg batt_s1_q;
   reg batt_s2_q;
   reg [NUM_SW-1:0] ret_s1_q;
   reg [NUM_SW-1:0] ret_s2_q;
   reg [1:0] init_q;
   reg [NUM_SW-1:0] set_v;
   reg [NUM_SW-1:0] clr_v;
   reg [NUM_SW-1:0] expire_v;
   reg [NUM_SW-1:0] word_d;
   // decoded command masks per path
   wire [NUM_SW-1:0] loc_set_w;
   wire [NUM_SW-1:0] loc_clr_w;
   wire [NUM_SW-1:0] rem_set_w;
   wire [NUM_SW-1:0] rem_clr_w;
   wire hk_ok_w;
   wire [NUM_SW-1:0] hk_set_w;
   wire [NUM_SW-1:0] hk_clr_w;
   wire init_done_w;
   integer i;
   integer j;
   integer k;

   // one-hot mask when a strobe carries the wanted code
   function [NUM_SW-1:0] cmd_mask;
      input valid;
      input [1:0] code;
      input [1:0] want;
      input [4:0] idx;
      begin
         if (valid && code == want)
            cmd_mask = onehot(idx);
         else
            cmd_mask = {NUM_SW{1'b0}};
      end
   endfunction

   // two-flop sync of battery status and stored word
   always @(posedge clk) begin
      batt_s1_q <= batt_ok_pin;
      batt_s2_q <= batt_s1_q;
      ret_s1_q <= retain_word;
      ret_s2_q <= ret_s1_q;
   end

   // init done once the restore cycle has passed
   assign init_done_w = (init_q == 2'h3);

   assign loc_set_w = cmd_mask(loc_cmd_valid, loc_cmd_code,
      `CISB_CMD_SET, loc_cmd_idx);
   assign loc_clr_w = cmd_mask(loc_cmd_valid, loc_cmd_code,
      `CISB_CMD_RESET, loc_cmd_idx);
   assign rem_set_w = cmd_mask(rem_cmd_valid, rem_cmd_code,
      `CISB_CMD_SET, rem_cmd_idx);
   assign rem_clr_w = cmd_mask(rem_cmd_valid, rem_cmd_code,
      `CISB_CMD_RESET, rem_cmd_idx);

   assign hk_ok_w = hk_cmd_valid && hk_q[hk_cmd_idx];
   assign hk_set_w = cmd_mask(hk_ok_w, hk_cmd_code, `CISB_CMD_SET,
      hk_cmd_idx) |
      cmd_mask(hk_ok_w, hk_cmd_code, `CISB_CMD_PULSE, hk_cmd_idx);
   assign hk_clr_w = cmd_mask(hk_ok_w, hk_cmd_code, `CISB_CMD_RESET,
      hk_cmd_idx);

   always @* begin
      expire_v = {NUM_SW{1'b0}};
      for (i = 0; i < NUM_SW; i = i + 1) begin
         if (mode_q[i] && sw_q[i] && cnt_q[i] == {{(CW-1){1'b0}}, 1'b1})
            expire_v[i] = 1'b1;
      end
   end

   always @* begin
      word_d = sw_q & ~expire_v;
      if (rem_word_we)
         word_d = rem_word_wdata;
      if (loc_word_we)
         word_d = loc_word_wdata;
   end

   always @* begin
      set_v = loc_set_w | rem_set_w | hk_set_w;
      clr_v = loc_clr_w | rem_clr_w | hk_clr_w;
      sw_d = (word_d & ~clr_v) | set_v;
      restart_d = (sw_d & ~sw_q) | set_v;
   end

   // switch state, restore on supply return
   always @(posedge clk) begin
      if (!rst_n) begin
         sw_q <= `CISB_STATE_RST;
         init_q <= 2'h0;
      end else if (init_q != 2'h3) begin
         init_q <= init_q + 2'h1;
         if (init_q == 2'h2 && batt_s2_q)
            sw_q <= ret_s2_q & ~mode_q;
         else if (init_q == 2'h2)
            sw_q <= `CISB_STATE_RST;
      end else begin
         sw_q <= sw_d;
      end
   end

   // per-switch pulse timers
   always @(posedge clk) begin
      for (j = 0; j < NUM_SW; j = j + 1) begin
         if (!rst_n || !init_done_w)
            cnt_q[j] <= {CW{1'b0}};
         else if (restart_d[j] && mode_q[j])
            cnt_q[j] <= PULSE_CYC[CW-1:0];
         else if (cnt_q[j] != {CW{1'b0}})
            cnt_q[j] <= cnt_q[j] - {{(CW-1){1'b0}}, 1'b1};
      end
   end

   // latched/pulsed word
   always @(posedge clk) begin
      if (!rst_n)
         mode_q <= `CISB_MODE_RST;
      else if (mode_we)
         mode_q <= mode_wdata;
   end

   // hotkey assignment word, all assigned after reset
   always @(posedge clk) begin
      if (!rst_n)
         hk_q <= `CISB_HOTKEY_RST;
      else if (hotkey_we)
         hk_q <= hotkey_wdata;
   end

   // label selectors, display wording only
   always @(posedge clk) begin
      for (k = 0; k < NUM_SW; k = k + 1) begin
         if (!rst_n)
            label_q[k] <= `CISB_LBL_SET_RESET;
         else if (label_we && label_idx == k[4:0])
            label_q[k] <= label_wdata;
      end
   end

   always @(posedge clk) begin
      if (!rst_n)
         switch_state_word <= `CISB_STATE_RST;
      else
         switch_state_word <= sw_q;
   end

   always @(posedge clk) begin
      if (!rst_n)
         switch_logic_signals <= `CISB_STATE_RST;
      else
         switch_logic_signals <= sw_q;
   end

   // configuration readback
   always @(posedge clk) begin
      if (!rst_n) begin
         hotkey_assign_word <= `CISB_HOTKEY_RST;
         mode_word <= `CISB_MODE_RST;
      end else begin
         hotkey_assign_word <= hk_q;
         mode_word <= mode_q;
      end
   end

   // label readback, one cycle after the index
   always @(posedge clk) begin
      if (!rst_n)
         label_rd_data <= `CISB_LBL_SET_RESET;
      else
         label_rd_data <= label_q[label_rd_idx];
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         retain_we <= 1'b0;
         retain_wdata <= `CISB_STATE_RST;
      end else begin
         retain_we <= init_done_w;
         retain_wdata <= sw_q & ~mode_q;
      end
   end

endmodule // cisb_switch_bank

// ### test/cisb_host.sv
// host model: local menu, remote serial and hotkey paths
`timescale 1ns/100ps
module cisb_host (
   input wire clk, // system clock
   output reg loc_word_we, rem_word_we, loc_cmd_valid, rem_cmd_valid,
   output reg hk_cmd_valid, // strobes
   output reg [31:0] loc_word_wdata, rem_word_wdata, // word data
   output reg [4:0] loc_cmd_idx, rem_cmd_idx, hk_cmd_idx, // indices
   output reg [1:0] loc_cmd_code, rem_cmd_code, hk_cmd_code // codes
);
   initial {loc_word_we, loc_word_wdata, rem_word_we, rem_word_wdata,
      loc_cmd_valid, loc_cmd_idx, loc_cmd_code, rem_cmd_valid, rem_cmd_idx,
      rem_cmd_code, hk_cmd_valid, hk_cmd_idx, hk_cmd_code} = 90'h0;
   // one-cycle word write, local when p is 0, then data is scrambled
   task word(input p, input [31:0] d);
      @(negedge clk);
      if (p) {rem_word_we, rem_word_wdata} = {1'h1, d};
      else {loc_word_we, loc_word_wdata} = {1'h1, d};
      @(negedge clk);
      {loc_word_we, rem_word_we} = 2'h0;
      {loc_word_wdata, rem_word_wdata} = ~{loc_word_wdata, rem_word_wdata};
   endtask
   task cmd(input [1:0] p, input [4:0] i, input [1:0] c);
      @(negedge clk);
      case (p)
         2'h0: {loc_cmd_valid, loc_cmd_idx, loc_cmd_code} = {1'h1, i, c};
         2'h1: {rem_cmd_valid, rem_cmd_idx, rem_cmd_code} = {1'h1, i, c};
         default: {hk_cmd_valid, hk_cmd_idx, hk_cmd_code} = {1'h1, i, c};
      endcase
      @(negedge clk);
      {loc_cmd_valid, rem_cmd_valid, hk_cmd_valid} = 3'h0;
      {loc_cmd_idx, rem_cmd_idx, hk_cmd_idx} = ~{loc_cmd_idx, rem_cmd_idx,
         hk_cmd_idx};
   endtask
endmodule // cisb_host

// ### test/cisb_props_properties.sv
// checker properties for the switch bank ports
`timescale 1ns/100ps
module cisb_props #(parameter PULSE_CYC = 20) (
   input wire clk, rst_n, loc_word_we, loc_cmd_valid, rem_cmd_valid,
   input wire hk_cmd_valid, mode_we, hotkey_we, retain_we,
   input wire [4:0] loc_cmd_idx, rem_cmd_idx,
   input wire [1:0] loc_cmd_code, rem_cmd_code,
   input wire [31:0] loc_word_wdata, mode_wdata, hotkey_wdata, mode_word,
   input wire [31:0] switch_state_word, switch_logic_signals,
   input wire [31:0] hotkey_assign_word, retain_wdata
);
   reg [2:0] up_q;
   wire up = up_q == 3'h7;
   wire quiet = !loc_cmd_valid && !rem_cmd_valid && !hk_cmd_valid;
   // cycles since reset release, saturating
   always @(posedge clk) up_q <= !rst_n ? 3'h0 : up_q + {2'h0, !up};
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic_mirror_a: assert property (
      switch_logic_signals == switch_state_word) else $error("mirror");
   word_write_a: assert property (
      up && loc_word_we && quiet |-> ##2
      switch_state_word == $past(loc_word_wdata, 2)) else $error("word");
   set_cmd_a: assert property (
      up && loc_cmd_valid && loc_cmd_code == 2'h1 |-> ##2
      switch_state_word[$past(loc_cmd_idx, 2)]) else $error("set");
   rem_reset_a: assert property (
      up && rem_cmd_valid && rem_cmd_code == 2'h2 && !loc_cmd_valid &&
      !hk_cmd_valid |-> ##2 !switch_state_word[$past(rem_cmd_idx, 2)])
      else $error("remote reset");
   reset_vals_a: assert property (
      $rose(rst_n) |-> switch_state_word == 32'h0 && mode_word == 32'h0 &&
      hotkey_assign_word == 32'hFFFFFFFF && !retain_we) else $error("rst");
   retain_excl_a: assert property (
      retain_we && $stable(mode_word) |-> (retain_wdata & mode_word) == 32'h0)
      else $error("pulsed retained");
   mode_write_a: assert property (
      up && mode_we |-> ##2 mode_word == $past(mode_wdata, 2))
      else $error("mode");
   hotkey_write_a: assert property (
      up && hotkey_we |-> ##2 hotkey_assign_word == $past(hotkey_wdata, 2))
      else $error("hotkey");
   cover property (up && hk_cmd_valid);
   cover property (up && loc_word_we && loc_cmd_valid);
   cover property ($fell(switch_state_word[5]) && mode_word[5]);
endmodule // cisb_props
bind cisb_switch_bank cisb_props #(.PULSE_CYC(PULSE_CYC)) chk (.*);

// ### test/cisb_switch_bank_tb.sv
// testbench for the switch bank
`timescale 1ns/100ps
module cisb_switch_bank_tb;
   localparam PC = 20;
   wire loc_word_we, rem_word_we, loc_cmd_valid, rem_cmd_valid, retain_we;
   wire hk_cmd_valid;
   wire [31:0] loc_word_wdata, rem_word_wdata, switch_state_word, mode_word;
   wire [31:0] switch_logic_signals, hotkey_assign_word, retain_wdata;
   wire [4:0] loc_cmd_idx, rem_cmd_idx, hk_cmd_idx;
   wire [1:0] loc_cmd_code, rem_cmd_code, hk_cmd_code, label_rd_data;
   reg clk, rst_n, mode_we, hotkey_we, label_we, batt_ok_pin;
   reg [31:0] mode_wdata, hotkey_wdata, retain_word;
   reg [4:0] label_idx, label_rd_idx;
   reg [1:0] label_wdata, k;
   integer miscompares, num_checks, n;
   cisb_switch_bank #(.PULSE_CYC(PC)) dut (.*);
   cisb_host host (.*);
   task chk(input [31:0] g, e);
      num_checks = num_checks + 1;
      if (g !== e) begin
         miscompares = miscompares + 1;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task test_done;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task cyc(input integer c);
      repeat (c) @(negedge clk);
   endtask
   task rst(input b);
      rst_n = 1'h0;
      batt_ok_pin = b;
      cyc(20);
      rst_n = 1'h1;
      cyc(8);
   endtask
   task wchk(input p, input [31:0] d);
      host.word(p, d);
      cyc(2);
      chk(switch_state_word, d);
   endtask
   task cchk(input [1:0] p, input [4:0] i, input [1:0] c, input b);
      host.cmd(p, i, c);
      cyc(2);
      chk({31'h0, switch_state_word[i]}, {31'h0, b});
   endtask
   task t_word;
      wchk(1'h0, 32'hA5A5F00F);
      chk(switch_logic_signals, 32'hA5A5F00F);
      wchk(1'h1, 32'h5A5A0FF0);
      fork
         host.word(1'h0, 32'h0);
         host.cmd(2'h0, 5'h4, 2'h1);
      join
      cyc(2);
      chk(switch_state_word, 32'h10);
   endtask
   task t_cmd;
      for (k = 2'h0; k < 2'h2; k = k + 2'h1) begin
         cchk(k, 5'h1F, 2'h1, 1'h1);
         cchk(k, 5'h1F, 2'h0, 1'h1);
         cchk(k, 5'h1F, 2'h3, 1'h1);
         cchk(k, 5'h1F, 2'h2, 1'h0);
      end
   endtask
   task t_hot;
      @(negedge clk);
      {mode_we, mode_wdata, hotkey_we, hotkey_wdata} = {33'h100000020,
         33'h100000080};
      @(negedge clk);
      {mode_we, hotkey_we} = 2'h0;
      cyc(2);
      chk(hotkey_assign_word, 32'h80);
      chk(mode_word, 32'h20);
      cchk(2'h2, 5'h7, 2'h1, 1'h1);
      cchk(2'h2, 5'h8, 2'h1, 1'h0);
      cchk(2'h2, 5'h7, 2'h2, 1'h0);
      cchk(2'h2, 5'h7, 2'h3, 1'h1);
      cchk(2'h0, 5'h5, 2'h1, 1'h1);
      chk(retain_wdata, 32'h90);
      cyc(10);
      cchk(2'h1, 5'h5, 2'h1, 1'h1);
      cyc(PC - 6);
      chk(switch_state_word, 32'hB0);
      cyc(10);
      chk(switch_state_word, 32'h90);
   endtask
   task t_label;
      for (n = 0; n < 4; n = n + 1) begin
         @(negedge clk);
         {label_we, label_idx, label_wdata, label_rd_idx} = {6'h29,
            n[1:0], 5'h9};
         @(negedge clk);
         label_we = 1'h0;
         cyc(2);
         chk({30'h0, label_rd_data}, n);
      end
      chk(switch_state_word, 32'h90);
   endtask
   always #25 clk = ~clk;
   // main sequence
   initial begin
      {clk, rst_n, mode_we, hotkey_we, label_we, batt_ok_pin} = 6'h0;
      {mode_wdata, hotkey_wdata, label_idx, label_rd_idx} = 74'h0;
      {retain_word, label_wdata, miscompares, num_checks} = 98'h0;
      rst(1'h0);
      chk(switch_state_word, 32'h0);
      chk(hotkey_assign_word, 32'hFFFFFFFF);
      t_word;
      t_cmd;
      t_hot;
      t_label;
      retain_word = 32'h90;
      rst(1'h1);
      chk(switch_state_word, 32'h90);
      rst(1'h0);
      chk(switch_state_word, 32'h0);
      test_done;
   end
   // watchdog
   initial begin
      #100000;
      miscompares = miscompares + 1;
      test_done;
   end
endmodule // cisb_switch_bank_tb
